// >>> pkg/dfa_pkg.sv
// Constants and types for the dual bus fractional arithmetic datapath
package dfa_pkg;
  localparam int DFA_DW = 24;
  localparam int DFA_EW = 8;
  localparam int DFA_AW = 2 * DFA_DW + DFA_EW;
  localparam int DFA_LW = 2 * DFA_DW;
  localparam logic [DFA_DW-1:0] DFA_OPND_RST = 24'h000000;
  localparam logic [DFA_AW-1:0] DFA_ACC_RST = 56'h00000000000000;
  localparam logic [DFA_LW-1:0] DFA_LIM_POS = 48'h7fffffffffff;
  localparam logic [DFA_LW-1:0] DFA_LIM_NEG = 48'h800000000000;
  localparam logic [DFA_DW-1:0] DFA_ZERO24 = 24'h000000;

  typedef enum logic [3:0] {
    DFA_R_X0 = 4'h0,
    DFA_R_X1 = 4'h1,
    DFA_R_Y0 = 4'h2,
    DFA_R_Y1 = 4'h3,
    DFA_R_A0 = 4'h4,
    DFA_R_A1 = 4'h5,
    DFA_R_A2 = 4'h6,
    DFA_R_B0 = 4'h7,
    DFA_R_B1 = 4'h8,
    DFA_R_B2 = 4'h9,
    DFA_R_A = 4'ha,
    DFA_R_B = 4'hb,
    DFA_R_X = 4'hc,
    DFA_R_Y = 4'hd,
    DFA_R_AR = 4'he,
    DFA_R_BR = 4'hf
  } dfa_reg_t;

  typedef enum logic [1:0] {
    DFA_SC_NONE = 2'h0,
    DFA_SC_DOWN = 2'h1,
    DFA_SC_UP = 2'h2,
    DFA_SC_RSVD = 2'h3
  } dfa_scale_t;

  typedef enum logic [2:0] {
    DFA_OP_NOP = 3'h0,
    DFA_OP_CLR = 3'h1,
    DFA_OP_MPY = 3'h2,
    DFA_OP_MAC = 3'h3,
    DFA_OP_MACN = 3'h4
  } dfa_op_t;

  typedef enum logic [1:0] {
    DFA_S_X0 = 2'h0,
    DFA_S_X1 = 2'h1,
    DFA_S_Y0 = 2'h2,
    DFA_S_Y1 = 2'h3
  } dfa_src_t;
endpackage

// >>> core/dfa_alu.sv
// Dual bus fractional datapath: operands, accumulators, MAC, shifter/limiters
`timescale 1ns/100ps

module dfa_shift_limit
  import dfa_pkg::*;
(
  input wire logic [DFA_AW-1:0] acc,
  input wire dfa_pkg::dfa_scale_t scale,
  output logic [DFA_LW-1:0] result,
  output logic ovf
);
  logic [DFA_AW-1:0] shifted;
  always_comb begin
    case (scale)
      DFA_SC_UP: shifted = {acc[DFA_AW-2:0], 1'b0};
      DFA_SC_DOWN: shifted = {acc[DFA_AW-1], acc[DFA_AW-1:1]};
      default: shifted = acc;
    endcase
    // Fits only when extension and body msb all equal
    ovf = !((&shifted[DFA_AW-1:DFA_LW-1]) || !(|shifted[DFA_AW-1:DFA_LW-1]));
    if (ovf) begin
      result = acc[DFA_AW-1] ? DFA_LIM_NEG : DFA_LIM_POS;
    end else begin
      result = shifted[DFA_LW-1:0];
    end
  end
endmodule // dfa_shift_limit

module dfa_alu
  import dfa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire dfa_pkg::dfa_scale_t scale_mode,
  input wire logic op_valid,
  input wire dfa_pkg::dfa_op_t op_code,
  input wire dfa_pkg::dfa_src_t op_src1,
  input wire dfa_pkg::dfa_src_t op_src2,
  input wire logic op_acc_b,
  input wire logic first_wr_en,
  input wire dfa_pkg::dfa_reg_t first_wr_sel,
  input wire logic [DFA_DW-1:0] first_operand_bus_in,
  input wire logic second_wr_en,
  input wire dfa_pkg::dfa_reg_t second_wr_sel,
  input wire logic [DFA_DW-1:0] second_operand_bus_in,
  input wire logic long_wr_en,
  input wire dfa_pkg::dfa_reg_t long_wr_sel,
  input wire logic first_rd_en,
  input wire dfa_pkg::dfa_reg_t first_rd_sel,
  input wire logic second_rd_en,
  input wire dfa_pkg::dfa_reg_t second_rd_sel,
  input wire logic long_rd_en,
  input wire dfa_pkg::dfa_reg_t long_rd_sel,
  output logic [DFA_DW-1:0] first_operand_bus_out,
  output logic [DFA_DW-1:0] second_operand_bus_out,
  output logic first_rd_ovf,
  output logic second_rd_ovf,
  input wire logic limit_clr,
  output logic limit_err
);
  logic [DFA_DW-1:0] x0_q, x0_d, x1_q, x1_d, y0_q, y0_d, y1_q, y1_d;
  logic [DFA_AW-1:0] a_q, a_d, b_q, b_d;
  logic [DFA_DW-1:0] fo_q, fo_d, so_q, so_d;
  logic fov_q, fov_d, sov_q, sov_d, err_q, err_d;
  logic [DFA_DW-1:0] m1, m2, acc_wdata;
  logic signed [DFA_LW-1:0] prod;
  logic [DFA_AW-1:0] prod_ext, acc_sel, acc_new, lim_in0, lim_in1;
  logic [DFA_LW-1:0] lim_out0, lim_out1;
  logic lim_ovf0, lim_ovf1;
  logic wen [2];
  dfa_reg_t wsel [2];
  logic [DFA_DW-1:0] wdat [2];

  function automatic logic [DFA_DW-1:0] pick_src(dfa_src_t s, logic [DFA_DW-1:0] v0,
      logic [DFA_DW-1:0] v1, logic [DFA_DW-1:0] v2, logic [DFA_DW-1:0] v3);
    case (s)
      DFA_S_X0: pick_src = v0;
      DFA_S_X1: pick_src = v1;
      DFA_S_Y0: pick_src = v2;
      default: pick_src = v3;
    endcase
  endfunction

  function automatic logic is_limited(dfa_reg_t s);
    is_limited = (s == DFA_R_A) || (s == DFA_R_B);
  endfunction

  // Raw 24-bit view of a register, extension read sign-extended
  function automatic logic [DFA_DW-1:0] raw24(dfa_reg_t s, logic [DFA_DW-1:0] vx0,
      logic [DFA_DW-1:0] vx1, logic [DFA_DW-1:0] vy0, logic [DFA_DW-1:0] vy1,
      logic [DFA_AW-1:0] va, logic [DFA_AW-1:0] vb);
    case (s)
      DFA_R_X0: raw24 = vx0;
      DFA_R_X1: raw24 = vx1;
      DFA_R_Y0: raw24 = vy0;
      DFA_R_Y1: raw24 = vy1;
      DFA_R_A0: raw24 = va[DFA_DW-1:0];
      DFA_R_A1: raw24 = va[DFA_LW-1:DFA_DW];
      DFA_R_A2: raw24 = {{(DFA_DW-DFA_EW){va[DFA_AW-1]}}, va[DFA_AW-1:DFA_LW]};
      DFA_R_B0: raw24 = vb[DFA_DW-1:0];
      DFA_R_B1: raw24 = vb[DFA_LW-1:DFA_DW];
      DFA_R_B2: raw24 = {{(DFA_DW-DFA_EW){vb[DFA_AW-1]}}, vb[DFA_AW-1:DFA_LW]};
      default: raw24 = DFA_ZERO24;
    endcase
  endfunction

  // Single-cycle signed fractional multiply
  always_comb begin
    m1 = pick_src(op_src1, x0_q, x1_q, y0_q, y1_q);
    m2 = pick_src(op_src2, x0_q, x1_q, y0_q, y1_q);
    prod = $signed(m1) * $signed(m2);
    prod_ext = {{(DFA_EW-1){prod[DFA_LW-1]}}, prod, 1'b0};
    acc_sel = op_acc_b ? b_q : a_q;
    case (op_code)
      DFA_OP_CLR: acc_new = DFA_ACC_RST;
      DFA_OP_MPY: acc_new = prod_ext;
      DFA_OP_MAC: acc_new = acc_sel + prod_ext;
      DFA_OP_MACN: acc_new = acc_sel - prod_ext;
      default: acc_new = acc_sel;
    endcase
  end

  // Two limiters so both buses read accumulators together
  always_comb begin
    lim_in0 = ((long_rd_en ? long_rd_sel : first_rd_sel) == DFA_R_B) ? b_q : a_q;
    lim_in1 = (second_rd_sel == DFA_R_B) ? b_q : a_q;
  end

  dfa_shift_limit u_lim0 (.acc(lim_in0), .scale(scale_mode), .result(lim_out0), .ovf(lim_ovf0));
  dfa_shift_limit u_lim1 (.acc(lim_in1), .scale(scale_mode), .result(lim_out1), .ovf(lim_ovf1));

  assign wen[0] = second_wr_en;
  assign wsel[0] = second_wr_sel;
  assign wdat[0] = second_operand_bus_in;
  assign wen[1] = first_wr_en;
  assign wsel[1] = first_wr_sel;
  assign wdat[1] = first_operand_bus_in;

  // Register file next state: ALU result, then bus writes override
  always_comb begin
    x0_d = x0_q;
    x1_d = x1_q;
    y0_d = y0_q;
    y1_d = y1_q;
    a_d = a_q;
    b_d = b_q;
    acc_wdata = DFA_ZERO24;
    if (op_valid && op_code != DFA_OP_NOP) begin
      if (op_acc_b) begin
        b_d = acc_new;
      end else begin
        a_d = acc_new;
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (wen[k]) begin
        acc_wdata = wdat[k];
        case (wsel[k])
          DFA_R_X0: x0_d = acc_wdata;
          DFA_R_X1: x1_d = acc_wdata;
          DFA_R_Y0: y0_d = acc_wdata;
          DFA_R_Y1: y1_d = acc_wdata;
          DFA_R_A0: a_d[DFA_DW-1:0] = acc_wdata;
          DFA_R_A1: a_d[DFA_LW-1:DFA_DW] = acc_wdata;
          DFA_R_A2: a_d[DFA_AW-1:DFA_LW] = acc_wdata[DFA_EW-1:0];
          DFA_R_B0: b_d[DFA_DW-1:0] = acc_wdata;
          DFA_R_B1: b_d[DFA_LW-1:DFA_DW] = acc_wdata;
          DFA_R_B2: b_d[DFA_AW-1:DFA_LW] = acc_wdata[DFA_EW-1:0];
          DFA_R_A: a_d = {{DFA_EW{acc_wdata[DFA_DW-1]}}, acc_wdata, DFA_ZERO24};
          DFA_R_B: b_d = {{DFA_EW{acc_wdata[DFA_DW-1]}}, acc_wdata, DFA_ZERO24};
          default: ;
        endcase
      end
    end
    if (long_wr_en) begin
      case (long_wr_sel)
        DFA_R_X: begin
          x1_d = first_operand_bus_in;
          x0_d = second_operand_bus_in;
        end
        DFA_R_Y: begin
          y1_d = first_operand_bus_in;
          y0_d = second_operand_bus_in;
        end
        DFA_R_A, DFA_R_AR: begin
          a_d = {{DFA_EW{first_operand_bus_in[DFA_DW-1]}}, first_operand_bus_in,
                 second_operand_bus_in};
        end
        DFA_R_B, DFA_R_BR: begin
          b_d = {{DFA_EW{first_operand_bus_in[DFA_DW-1]}}, first_operand_bus_in,
                 second_operand_bus_in};
        end
        default: ;
      endcase
    end
  end

  // Bus read data, overflow indication and sticky error flag
  always_comb begin
    fo_d = fo_q;
    so_d = so_q;
    fov_d = 1'b0;
    sov_d = 1'b0;
    if (long_rd_en) begin
      case (long_rd_sel)
        DFA_R_X: begin
          fo_d = x1_q;
          so_d = x0_q;
        end
        DFA_R_Y: begin
          fo_d = y1_q;
          so_d = y0_q;
        end
        DFA_R_AR: begin
          fo_d = a_q[DFA_LW-1:DFA_DW];
          so_d = a_q[DFA_DW-1:0];
        end
        DFA_R_BR: begin
          fo_d = b_q[DFA_LW-1:DFA_DW];
          so_d = b_q[DFA_DW-1:0];
        end
        DFA_R_A, DFA_R_B: begin
          fo_d = lim_out0[DFA_LW-1:DFA_DW];
          so_d = lim_out0[DFA_DW-1:0];
          fov_d = lim_ovf0;
          sov_d = lim_ovf0;
        end
        default: begin
          fo_d = DFA_ZERO24;
          so_d = DFA_ZERO24;
        end
      endcase
    end else begin
      if (first_rd_en) begin
        if (is_limited(first_rd_sel)) begin
          fo_d = lim_out0[DFA_LW-1:DFA_DW];
          fov_d = lim_ovf0;
        end else begin
          fo_d = raw24(first_rd_sel, x0_q, x1_q, y0_q, y1_q, a_q, b_q);
        end
      end
      if (second_rd_en) begin
        if (is_limited(second_rd_sel)) begin
          so_d = lim_out1[DFA_LW-1:DFA_DW];
          sov_d = lim_ovf1;
        end else begin
          so_d = raw24(second_rd_sel, x0_q, x1_q, y0_q, y1_q, a_q, b_q);
        end
      end
    end
    // Set wins over clear; clean reads never clear
    err_d = (err_q && !limit_clr) || fov_d || sov_d;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      x0_q <= DFA_OPND_RST;
      x1_q <= DFA_OPND_RST;
      y0_q <= DFA_OPND_RST;
      y1_q <= DFA_OPND_RST;
      a_q <= DFA_ACC_RST;
      b_q <= DFA_ACC_RST;
      fo_q <= DFA_ZERO24;
      so_q <= DFA_ZERO24;
      fov_q <= 1'b0;
      sov_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      x0_q <= x0_d;
      x1_q <= x1_d;
      y0_q <= y0_d;
      y1_q <= y1_d;
      a_q <= a_d;
      b_q <= b_d;
      fo_q <= fo_d;
      so_q <= so_d;
      fov_q <= fov_d;
      sov_q <= sov_d;
      err_q <= err_d;
    end
  end

  assign first_operand_bus_out = fo_q;
  assign second_operand_bus_out = so_q;
  assign first_rd_ovf = fov_q;
  assign second_rd_ovf = sov_q;
  assign limit_err = err_q;
endmodule // dfa_alu

// >>> sim/dfa_alu_props.sv
// Checker for the datapath read, limiter and error flag ports
`timescale 1ns/100ps
module dfa_alu_props
  import dfa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic first_wr_en,
  input wire dfa_pkg::dfa_reg_t first_wr_sel,
  input wire logic [DFA_DW-1:0] first_operand_bus_in,
  input wire logic long_wr_en,
  input wire logic first_rd_en,
  input wire dfa_pkg::dfa_reg_t first_rd_sel,
  input wire logic long_rd_en,
  input wire logic [DFA_DW-1:0] first_operand_bus_out,
  input wire logic [DFA_DW-1:0] second_operand_bus_out,
  input wire logic first_rd_ovf,
  input wire logic second_rd_ovf,
  input wire logic limit_clr,
  input wire logic limit_err
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_set; first_rd_ovf || second_rd_ovf |-> limit_err; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_sticky; limit_err && !limit_clr |=> limit_err; endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_clr; limit_clr |=> !limit_err || first_rd_ovf || second_rd_ovf; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_src; first_rd_ovf |-> $past(first_rd_en || long_rd_en); endproperty
  a_src: assert property (p_src) else $error("overflow without read");
  property p_raw;
    first_rd_en && !long_rd_en && first_rd_sel inside {[DFA_R_X0:DFA_R_B2]} |=> !first_rd_ovf;
  endproperty
  a_raw: assert property (p_raw) else $error("raw read limited");
  property p_sat; first_rd_ovf |-> first_operand_bus_out inside {24'h7fffff, 24'h800000}; endproperty
  a_sat: assert property (p_sat) else $error("bad limit value");
  property p_long; long_rd_en |=> first_rd_ovf == second_rd_ovf; endproperty
  a_long: assert property (p_long) else $error("long read flags differ");
  property p_hold; !first_rd_en && !long_rd_en |=> $stable(first_operand_bus_out); endproperty
  a_hold: assert property (p_hold) else $error("bus out moved");
  property p_wr_rd;
    first_wr_en && !long_wr_en && first_wr_sel == DFA_R_X0 ##1
      first_rd_en && !long_rd_en && first_rd_sel == DFA_R_X0
      |=> first_operand_bus_out == $past(first_operand_bus_in, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("write then read differs");
  c_ovf: cover property (first_rd_ovf);
  c_clr: cover property (limit_err ##1 !limit_err);
  c_long: cover property (long_rd_en ##1 second_rd_ovf);
endmodule // dfa_alu_props
bind dfa_alu dfa_alu_props chk_u (.clk_sys(clk_sys), .rst(rst), .first_wr_en(first_wr_en),
  .first_wr_sel(first_wr_sel), .first_operand_bus_in(first_operand_bus_in),
  .long_wr_en(long_wr_en), .first_rd_en(first_rd_en), .first_rd_sel(first_rd_sel),
  .long_rd_en(long_rd_en), .first_operand_bus_out(first_operand_bus_out),
  .second_operand_bus_out(second_operand_bus_out), .first_rd_ovf(first_rd_ovf),
  .second_rd_ovf(second_rd_ovf), .limit_clr(limit_clr), .limit_err(limit_err));

// >>> sim/dfa_seq_model.sv
// Sequencer model issuing one operation per request
`timescale 1ns/100ps
module dfa_seq_model
  import dfa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic go,
  input wire dfa_pkg::dfa_op_t code,
  output logic op_valid,
  output dfa_pkg::dfa_op_t op_code
);
  initial begin
    op_valid = 1'b0;
    op_code = DFA_OP_NOP;
  end
  always @(posedge clk_sys) begin
    op_valid <= #1 go;
    op_code <= #1 go ? code : DFA_OP_NOP;
  end
endmodule // dfa_seq_model

// >>> sim/dual_bus_fractional_alu_tb.sv
// Testbench for the dual bus fractional datapath
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module dual_bus_fractional_alu_tb;
  import dfa_pkg::*;
  logic clk_sys = 0, rst = 1, go = 0, acc_b = 0, clr = 0, op_valid, v1, v2, err;
  logic w1 = 0, w2 = 0, wl = 0, r1 = 0, r2 = 0, rl = 0;
  logic [23:0] d1 = 0, d2 = 0, o1, o2;
  dfa_scale_t scale = DFA_SC_NONE;
  dfa_op_t code = DFA_OP_NOP, opc;
  dfa_src_t s1 = DFA_S_X0, s2 = DFA_S_Y0;
  dfa_reg_t ws1 = DFA_R_X, ws2 = DFA_R_X, rs1 = DFA_R_X0, rs2 = DFA_R_X0, rsl = DFA_R_A;
  dfa_reg_t wls = DFA_R_X;
  int fail_count = 0, tests_run = 0, cycles = 0;
  dfa_seq_model model_u (.clk_sys(clk_sys), .go(go), .code(code), .op_valid(op_valid),
    .op_code(opc));
  dfa_alu dut_u (.clk_sys(clk_sys), .rst(rst), .scale_mode(scale), .op_valid(op_valid),
    .op_code(opc), .op_src1(s1), .op_src2(s2), .op_acc_b(acc_b), .first_wr_en(w1),
    .first_wr_sel(ws1), .first_operand_bus_in(d1), .second_wr_en(w2), .second_wr_sel(ws2),
    .second_operand_bus_in(d2), .long_wr_en(wl), .long_wr_sel(wls), .first_rd_en(r1),
    .first_rd_sel(rs1), .second_rd_en(r2), .second_rd_sel(rs2), .long_rd_en(rl),
    .long_rd_sel(rsl), .first_operand_bus_out(o1), .second_operand_bus_out(o2),
    .first_rd_ovf(v1), .second_rd_ovf(v2), .limit_clr(clr), .limit_err(err));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task cyc; @(posedge clk_sys); #1; endtask
  task wr2(input dfa_reg_t a, input logic [23:0] da, input dfa_reg_t b, input logic [23:0] db);
    w1 = 1; w2 = 1; ws1 = a; d1 = da; ws2 = b; d2 = db;
    cyc;
    w1 = 0; w2 = 0;
  endtask
  task rd2(input dfa_reg_t a, b, input logic [23:0] ea, eb, input logic oa, ob);
    r1 = 1; r2 = 1; rs1 = a; rs2 = b;
    cyc;
    r1 = 0;
    r2 = 0;
    `CHK(o1, ea)
    `CHK(o2, eb)
    `CHK(v1, oa)
    `CHK(v2, ob)
    cyc;
  endtask
  task op(input dfa_op_t c);
    go = 1; code = c;
    cyc;
    go = 0;
    cyc;
  endtask
  task t_regs;
    wr2(DFA_R_X0, 24'h123456, DFA_R_Y1, 24'hfedcba);
    rd2(DFA_R_X0, DFA_R_Y1, 24'h123456, 24'hfedcba, 0, 0);
    rd2(DFA_R_Y1, DFA_R_X0, 24'hfedcba, 24'h123456, 0, 0);
    $display("t_regs done");
  endtask
  task t_mac;
    wr2(DFA_R_X0, 24'h400000, DFA_R_Y0, 24'h400000);
    op(DFA_OP_MPY);
    rd2(DFA_R_A, DFA_R_A1, 24'h200000, 24'h200000, 0, 0);
    op(DFA_OP_MAC);
    rd2(DFA_R_A1, DFA_R_A0, 24'h400000, 24'h000000, 0, 0);
    $display("t_mac done");
  endtask
  task t_scale;
    scale = DFA_SC_DOWN;
    rd2(DFA_R_A, DFA_R_A, 24'h200000, 24'h200000, 0, 0);
    scale = DFA_SC_UP;
    rd2(DFA_R_A, DFA_R_A, 24'h7fffff, 24'h7fffff, 1, 1);
    `CHK(err, 1'b1)
    scale = DFA_SC_RSVD;
    rd2(DFA_R_A, DFA_R_B, 24'h400000, 24'h000000, 0, 0);
    scale = DFA_SC_NONE;
    rd2(DFA_R_A, DFA_R_A, 24'h400000, 24'h400000, 0, 0);
    `CHK(err, 1'b1)
    clr = 1;
    cyc;
    clr = 0;
    `CHK(err, 1'b0)
    $display("t_scale done");
  endtask
  task t_neg;
    acc_b = 1; s1 = DFA_S_X1;
    wr2(DFA_R_X1, 24'hc00000, DFA_R_X, 24'h000000);
    op(DFA_OP_MPY);
    rd2(DFA_R_B1, DFA_R_B2, 24'he00000, 24'hffffff, 0, 0);
    op(DFA_OP_MACN);
    rd2(DFA_R_B1, DFA_R_B, 24'h000000, 24'h000000, 0, 0);
    wr2(DFA_R_A2, 24'h000080, DFA_R_X, 24'h000000);
    rd2(DFA_R_A, DFA_R_A, 24'h800000, 24'h800000, 1, 1);
    rl = 1; rsl = DFA_R_A;
    cyc;
    rl = 0;
    `CHK(o1, 24'h800000)
    `CHK(o2, 24'h000000)
    `CHK(v1, 1'b1)
    `CHK(v2, 1'b1)
    acc_b = 0;
    op(DFA_OP_CLR);
    rd2(DFA_R_A, DFA_R_A2, 24'h000000, 24'h000000, 0, 0);
    $display("t_neg done");
  endtask
  task t_long;
    wl = 1;
    wls = DFA_R_X;
    d1 = 24'h400000;
    d2 = 24'h200000;
    cyc;
    wls = DFA_R_B;
    d1 = 24'h7fffff;
    d2 = 24'habcdef;
    cyc;
    wl = 0;
    rl = 1;
    rsl = DFA_R_X;
    cyc;
    `CHK(o1, 24'h400000)
    `CHK(o2, 24'h200000)
    rsl = DFA_R_BR;
    cyc;
    `CHK(o1, 24'h7fffff)
    `CHK(o2, 24'habcdef)
    `CHK(v1, 1'b0)
    `CHK(v2, 1'b0)
    scale = DFA_SC_UP;
    rsl = DFA_R_B;
    cyc;
    `CHK(o1, 24'h7fffff)
    `CHK(o2, 24'hffffff)
    `CHK(v1, 1'b1)
    `CHK(v2, 1'b1)
    rl = 0;
    scale = DFA_SC_NONE;
    s1 = DFA_S_X0;
    s2 = DFA_S_X1;
    op(DFA_OP_MPY);
    rd2(DFA_R_A1, DFA_R_A, 24'h100000, 24'h100000, 0, 0);
    $display("t_long done");
  endtask
  task t_reset;
    rst = 1;
    cyc;
    `CHK(o1, 24'h000000)
    `CHK(o2, 24'h000000)
    `CHK(err, 1'b0)
    rst = 0;
    cyc;
    rd2(DFA_R_X1, DFA_R_B1, 24'h000000, 24'h000000, 0, 0);
    $display("t_reset done");
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst = 0;
    t_regs;
    t_mac;
    t_scale;
    t_neg;
    t_long;
    t_reset;
    complete_run;
  end
endmodule // dual_bus_fractional_alu_tb
